// ===== testbench/parallel_port_mode_config_test.sv
`timescale 1ns/1ps
module parallel_port_mode_config_test;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, irq, slow, err;
  logic cs, rds, wrs, be, oe, w;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [10:0] pa;
  logic [7:0] din, dout, xb;
  logic [15:0] m;
  int badCount, nCompared, su, sc, ho, rs, lSu, lSc, lHo, lRs, nX, n0;
  logic [7:0] bq [$];

  parallel_port_mode_config parallel_port_mode_config_i (.clk(clk), .arst_n(arst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .port_chip_select(cs), .port_read_strobe(rds), .port_write_strobe(wrs),
    .port_byte_enable(be), .port_address_lines(pa), .port_data_lines_in(din),
    .port_data_lines_out(dout), .port_data_lines_oe(oe));
  pp_peripheral pp_peripheral_i (.clk(clk), .cs(cs), .wrStb(wrs), .oe(oe), .slow(slow),
    .addr(pa), .dout(dout), .din(din));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Port cycle monitor
  always @(posedge clk) begin
    if (cs) begin
      if (be) sc++;
      else if (sc == 0) su++;
      else ho++;
      if (rds) rs++;
      xb = dout;
    end else if (su + sc > 0) begin
      nX++;
      bq.push_back(xb);
      lSu = su;
      lSc = sc;
      lHo = ho;
      lRs = rs;
      su = 0;
      sc = 0;
      ho = 0;
      rs = 0;
    end
  end

  // ==========================================================
  // Bus tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    nCompared++;
    if (g !== e) begin
      badCount++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk);
    end
    if (n == 100) badCount++;
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    apb(1'b0, pp_pkg::OFF_MODE, 32'h0);
    while (rv[15] !== 1'b0 && n < 200) begin
      n++;
      apb(1'b0, pp_pkg::OFF_MODE, 32'h0);
    end
    if (n == 200) badCount++;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [10:0] stepped(input logic [10:0] a, input logic [1:0] s);
    if (s == pp_pkg::STEP_UP) return a + 11'h1;
    if (s == pp_pkg::STEP_DOWN) return a - 11'h1;
    return a;
  endfunction

  task automatic xfer(input logic [10:0] a, input logic [15:0] d);
    logic [31:0] eSu, eSc, eHo;
    logic [7:0] mb;
    eSc = 32'(m[5:2]) + 1;
    eSu = (m[5:2] == 4'h0) ? 1 : 32'(m[7:6]) + 1;
    eHo = (m[5:2] == 4'h0) ? 1 : 32'(m[1:0]) + 1;
    apb(1'b1, pp_pkg::OFF_MODE, 32'(m));
    apb(1'b1, pp_pkg::OFF_ADDR, 32'(a));
    apb(1'b1, pp_pkg::OFF_STAT, 32'h1);
    mb = pp_peripheral_i.mem[a];
    bq.delete();
    n0 = nX;
    apb(w, pp_pkg::OFF_DATA, 32'(d));
    apb(1'b0, pp_pkg::OFF_MODE, 32'h0);
    chk("busy", 32'h1, 32'(rv[15]));
    if (m[5:2] > 4'h1) apb(1'b1, pp_pkg::OFF_MODE, 32'(~m));
    waitIdle;
    chk("mode kept", 32'(m), rv & 32'hffff);
    chk("transfers", m[10] ? 2 : 1, nX - n0);
    chk("setup", eSu, lSu);
    chk("strobe", eSc, lSc);
    chk("hold", eHo, lHo);
    if (w) begin
      chk("first byte", 32'(d[7:0]), 32'(bq[0]));
      if (m[10]) chk("second byte", 32'(d[15:8]), 32'(bq[1]));
      chk("far byte", m[10] ? d[15:8] : d[7:0], pp_peripheral_i.mem[a]);
      chk("addr", 32'(stepped(a, m[12:11])), 32'(pa));
    end else begin
      apb(1'b0, pp_pkg::OFF_DATA, 32'h0);
      chk("read", m[10] ? {mb, mb} : mb, m[10] ? rv[15:0] : rv[7:0]);
      waitIdle;
      chk("rd strobe", m[8] ? eSu + eSc + eHo : eSc, lRs);
      chk("addr", 32'(stepped(stepped(a, m[12:11]), m[12:11])), 32'(pa));
    end
    apb(1'b0, pp_pkg::OFF_STAT, 32'h0);
    chk("status", (m[14:13] == pp_pkg::IRQ_EACH) ||
      (m[14:13] == pp_pkg::IRQ_BUFFER && a[1:0] == 2'h3), rv[0]);
    chk("irq", 32'(rv[0]), 32'(irq));
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #(20 * 40000);
    badCount++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    arst_n = 1'b0;
    {psel, penable, pwrite, slow, w} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    m = 16'h0000;
    void'($urandom(32'h00f0));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 5; k++) begin
      apb(1'b0, 12'(k * 4), 32'h0);
      chk("reset value", 32'h0, rv);
    end
    apb(1'b1, pp_pkg::OFF_MODE, 32'hffff);
    apb(1'b0, pp_pkg::OFF_MODE, 32'h0);
    chk("busy read only", 32'h7fff, rv);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", 32'h1, {rv[30:0], err});
    apb(1'b1, 12'h020, 32'h5);
    chk("unmapped wr", 32'h1, 32'(err));
    $display("test registers done");
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, pp_pkg::OFF_MODE, 32'(k) << 8);
      n0 = nX;
      apb(1'b1, pp_pkg::OFF_DATA, 32'h00a5);
      repeat (12) @(posedge clk);
      chk("slave no cycle", n0, nX);
    end
    $display("test slave done");
    apb(1'b1, pp_pkg::OFF_MASK, 32'h1);
    for (int i = 0; i < 16; i++) begin
      m = 16'($urandom) & 16'h7fff;
      m[14:13] = 2'(i);
      m[9:8] = {1'b1, i[2]};
      if (i == 0) m[7:0] = 8'hc3;
      if (i == 1) m[7:0] = 8'h3c;
      if (m[14:13] == pp_pkg::IRQ_BUFFER) m[12:11] = pp_pkg::STEP_HOLD;
      w = (i < 2) || i[3];
      slow = 1'($urandom);
      if (!w && m[5:2] < 4'h3) m[5:2] = 4'h3;
      if (!w && m[7:6] == 2'h0) m[7:6] = 2'h1;
      xfer(11'($urandom), 16'($urandom));
    end
    $display("test transfers done");
    m = 16'h2200;
    xfer(11'h003, 16'h1234);
    apb(1'b1, pp_pkg::OFF_MASK, 32'h0);
    chk("masked irq", 32'h0, 32'(irq));
    apb(1'b1, pp_pkg::OFF_STAT, 32'h1);
    apb(1'b0, pp_pkg::OFF_STAT, 32'h0);
    chk("status cleared", 32'h0, rv);
    $display("test interrupt done");
    summarize();
  end
endmodule

// ===== testbench/pp_peripheral.sv
`timescale 1ns/1ps
module pp_peripheral (
  input wire logic clk,
  input wire logic cs,
  input wire logic wrStb,
  input wire logic oe,
  input wire logic slow,
  input wire logic [10:0] addr,
  input wire logic [7:0] dout,
  output logic [7:0] din
);
  logic [7:0] mem [0:2047];
  logic [7:0] lastVal;
  logic [1:0] age;
  logic drive;
  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = 8'(i * 13 + 5);
    end
    lastVal = 8'h00;
    age = 2'h0;
  end
  // Slow answer starts one cycle later
  assign drive = cs && !oe && (age > {1'b0, slow});
  always @(posedge clk) begin
    if (cs && wrStb && oe) begin
      mem[addr] <= dout;
    end
    age <= (cs && !oe) ? ((age == 2'h3) ? age : age + 2'h1) : 2'h0;
    if (drive) begin
      lastVal <= mem[addr];
    end
  end
  // Released bus shows inverse of last value
  assign din = drive ? mem[addr] : ~lastVal;
endmodule

// ===== verilog/parallel_port_mode_config.sv
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module parallel_port_mode_config (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic port_chip_select,
  output logic port_read_strobe,
  output logic port_write_strobe,
  output logic port_byte_enable,
  output logic [10:0] port_address_lines,
  input wire logic [7:0] port_data_lines_in,
  output logic [7:0] port_data_lines_out,
  output logic port_data_lines_oe
);

  logic [14:0] modeReg;
  logic [10:0] addrReg;
  logic [15:0] dataWord;
  logic [15:0] readWord;
  logic busy;
  logic byteSel;
  logic isWrite;
  logic startPulse;
  logic statusBit;
  logic maskBit;
  logic [7:0] dataSync1;
  logic [7:0] dataSync2;

  strobe_if eng ();

  // ==========================================================================
  // Helpers
  // code plus one
  function automatic logic [4:0] waitLen(input logic [1:0] code);
    waitLen = {3'h0, code} + 5'h01;
  endfunction

  function automatic logic [10:0] stepAddr(input logic [10:0] addr, input logic [1:0] sel);
    case (sel)
      pp_pkg::STEP_UP: stepAddr = addr + 11'h001;
      pp_pkg::STEP_DOWN: stepAddr = addr - 11'h001;
      default: stepAddr = addr;
    endcase
  endfunction

  // ==========================================================================
  // Field decode
  logic [1:0] irqSel;
  logic [1:0] stepSel;
  logic wide;
  logic [1:0] portMode;
  logic [1:0] setupSel;
  logic [3:0] strobeSel;
  logic [1:0] holdSel;
  logic masterMode;
  logic mode1;

  assign irqSel = modeReg[pp_pkg::IRQ_HI:pp_pkg::IRQ_LO];
  assign stepSel = modeReg[pp_pkg::STEP_HI:pp_pkg::STEP_LO];
  assign wide = modeReg[pp_pkg::WIDE_BIT];
  assign portMode = modeReg[pp_pkg::MODE_HI:pp_pkg::MODE_LO];
  assign setupSel = modeReg[pp_pkg::SETUP_HI:pp_pkg::SETUP_LO];
  assign strobeSel = modeReg[pp_pkg::STROBE_HI:pp_pkg::STROBE_LO];
  assign holdSel = modeReg[pp_pkg::HOLD_HI:pp_pkg::HOLD_LO];
  // master pinning only in the two master codes
  assign masterMode = (portMode == pp_pkg::PORT_MASTER2) || (portMode == pp_pkg::PORT_MASTER1);
  assign mode1 = (portMode == pp_pkg::PORT_MASTER1);

  // ==========================================================================
  // APB decode
  logic access;
  logic setupPh;
  logic hitMode;
  logic hitAddr;
  logic hitData;
  logic hitStat;
  logic hitMask;
  logic mapped;
  logic wrMode;
  logic wrAddr;
  logic wrStat;
  logic wrMask;
  logic accept;
  logic [31:0] readValue;

  assign access = psel && penable;
  assign setupPh = psel && !penable;
  assign hitMode = (paddr == pp_pkg::OFF_MODE);
  assign hitAddr = (paddr == pp_pkg::OFF_ADDR);
  assign hitData = (paddr == pp_pkg::OFF_DATA);
  assign hitStat = (paddr == pp_pkg::OFF_STAT);
  assign hitMask = (paddr == pp_pkg::OFF_MASK);
  assign mapped = hitMode || hitAddr || hitData || hitStat || hitMask;
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign wrMode = access && pwrite && hitMode && !busy;
  assign wrAddr = access && pwrite && hitAddr && !busy;
  assign wrStat = access && pwrite && hitStat;
  assign wrMask = access && pwrite && hitMask;
  // Data accesses start bus cycles only in master modes when idle
  assign accept = access && hitData && masterMode && !busy;

  // busy shown in bit 15, above the mode fields
  assign readValue = hitMode ? {16'h0000, busy, modeReg} :
                     hitAddr ? {21'h000000, addrReg} :
                     hitData ? {16'h0000, readWord} :
                     hitStat ? {31'h00000000, statusBit} :
                     hitMask ? {31'h00000000, maskBit} : 32'h00000000;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h00000000;
    end else if (setupPh) begin
      prdata <= readValue;
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      modeReg <= pp_pkg::MODE_RESET;
    end else if (wrMode) begin
      modeReg <= pwdata[14:0];
    end
  end

  // ==========================================================================
  // Transfer control
  logic engDone;
  logic lastDone;
  logic secondStart;

  assign engDone = eng.done;
  // second byte after the low byte
  assign secondStart = engDone && wide && !byteSel;
  // narrow accesses finish after one byte
  assign lastDone = engDone && (!wide || byteSel);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      byteSel <= 1'b0;
      isWrite <= 1'b0;
      startPulse <= 1'b0;
    end else begin
      startPulse <= accept || secondStart;
      if (accept) begin
        busy <= 1'b1;
        byteSel <= 1'b0;
        isWrite <= pwrite;
      end else if (secondStart) begin
        byteSel <= 1'b1;
      end else if (lastDone) begin
        busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataWord <= 16'h0000;
      port_data_lines_out <= 8'h00;
    end else if (accept && pwrite) begin
      dataWord <= pwdata[15:0];
      port_data_lines_out <= pwdata[7:0];
    end else if (secondStart) begin
      port_data_lines_out <= dataWord[15:8];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      readWord <= 16'h0000;
    end else if (engDone && !isWrite) begin
      if (byteSel) begin
        readWord[15:8] <= eng.rdByte;
      end else begin
        readWord[7:0] <= eng.rdByte;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addrReg <= pp_pkg::ADDR_RESET;
    end else if (wrAddr) begin
      addrReg <= pwdata[10:0];
    end else if (lastDone) begin
      addrReg <= stepAddr(addrReg, stepSel);
    end
  end

  // ==========================================================================
  // Interrupt status
  logic irqEvent;

  assign irqEvent = lastDone && ((irqSel == pp_pkg::IRQ_EACH) ||
                    ((irqSel == pp_pkg::IRQ_BUFFER) && (addrReg[1:0] == pp_pkg::BUF_LAST)));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      statusBit <= 1'b0;
      maskBit <= 1'b0;
    end else begin
      if (irqEvent) begin
        statusBit <= 1'b1;
      end else if (wrStat && pwdata[0]) begin
        statusBit <= 1'b0;
      end
      if (wrMask) begin
        maskBit <= pwdata[0];
      end
    end
  end

  assign irq = statusBit && maskBit;

  // ==========================================================================
  // Bus cycle engine
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataSync1 <= 8'h00;
      dataSync2 <= 8'h00;
    end else begin
      dataSync1 <= port_data_lines_in;
      dataSync2 <= dataSync1;
    end
  end

  assign eng.start = startPulse;
  assign eng.isWrite = isWrite;
  assign eng.rdIn = dataSync2;
  // zero strobe code drops extra setup and hold
  assign eng.setupLen = (strobeSel == pp_pkg::STROBE_MIN) ? pp_pkg::LEN_ONE : waitLen(setupSel);
  assign eng.holdLen = (strobeSel == pp_pkg::STROBE_MIN) ? pp_pkg::LEN_ONE : waitLen(holdSel);
  // strobe of one plus the code
  assign eng.strobeLen = {1'b0, strobeSel} + 5'h01;

  strobe_engine u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .bus(eng.engine)
  );

  // ==========================================================================
  // Port pins
  logic engActive;
  logic inStrobe;

  assign engActive = (eng.phase != pp_pkg::PH_IDLE);
  assign inStrobe = (eng.phase == pp_pkg::PH_STROBE);
  assign port_chip_select = engActive;
  // separate strobes in master 2, direction and enable in master 1
  assign port_read_strobe = mode1 ? (engActive && !isWrite) : (inStrobe && !isWrite);
  assign port_write_strobe = mode1 ? inStrobe : (inStrobe && isWrite);
  assign port_byte_enable = inStrobe;
  assign port_address_lines = addrReg;
  assign port_data_lines_oe = engActive && isWrite;

  // ==========================================================================
  // Checks
  a_busy_covers_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    engActive |-> busy)
    else $error("Bus cycle runs without busy");
  a_busy_readback: assert property (@(posedge clk) disable iff (!arst_n)
    (setupPh && hitMode) |=> prdata[15] == $past(busy))
    else $error("Busy flag readback wrong");
  a_irq_off_mode: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && irqSel == pp_pkg::IRQ_OFF && !statusBit) |=> !statusBit)
    else $error("Event raised with interrupts off");
  a_irq_buffer_last: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && irqSel == pp_pkg::IRQ_BUFFER && addrReg[1:0] == 2'h3) |=> statusBit)
    else $error("Last buffer slot raised no event");
  a_addr_step_up: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && stepSel == pp_pkg::STEP_UP) |=> addrReg == $past(addrReg) + 11'h001)
    else $error("Address did not step up");
  a_narrow_single: assert property (@(posedge clk) disable iff (!arst_n)
    (engDone && !wide) |=> !busy && !engActive)
    else $error("Narrow access ran more than one byte");
  a_master2_strobes: assert property (@(posedge clk) disable iff (!arst_n)
    (portMode == pp_pkg::PORT_MASTER2 && inStrobe)
      |-> (port_write_strobe == isWrite) && (port_read_strobe == !isWrite))
    else $error("Master 2 strobe mismatch");
  a_no_extra_wait: assert property (@(posedge clk) disable iff (!arst_n)
    (strobeSel == 4'h0) |-> (eng.setupLen == 5'h01) && (eng.holdLen == 5'h01))
    else $error("Extra wait applied with zero strobe code");
  a_wide_low_first: assert property (@(posedge clk) disable iff (!arst_n)
    secondStart |=> byteSel && startPulse ##1 eng.phase == pp_pkg::PH_SETUP)
    else $error("High byte transfer did not follow");
  a_mode_frozen: assert property (@(posedge clk) disable iff (!arst_n)
    busy |=> $stable(modeReg))
    else $error("Mode changed during a transfer");
  a_slave_no_cycle: assert property (@(posedge clk) disable iff (!arst_n)
    (access && hitData && !masterMode) |=> !startPulse)
    else $error("Slave mode started a bus cycle");
  a_master1_read_level: assert property (@(posedge clk) disable iff (!arst_n)
    (mode1 && engActive && !isWrite) |-> port_read_strobe)
    else $error("Master 1 read level dropped");
  a_addr_step_down: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && stepSel == pp_pkg::STEP_DOWN) |=> addrReg == $past(addrReg) - 11'h001)
    else $error("Address did not step down");
  a_addr_step_hold: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && (stepSel == pp_pkg::STEP_HOLD || stepSel == pp_pkg::STEP_BUFFER))
      |=> $stable(addrReg))
    else $error("Address moved in hold step mode");
  a_irq_each_access: assert property (@(posedge clk) disable iff (!arst_n)
    (lastDone && irqSel == pp_pkg::IRQ_EACH) |=> statusBit)
    else $error("Completed access raised no event");
  a_status_clear: assert property (@(posedge clk) disable iff (!arst_n)
    (wrStat && pwdata[0] && !irqEvent) |=> !statusBit)
    else $error("Status bit not cleared by write");
  a_addr_frozen: assert property (@(posedge clk) disable iff (!arst_n)
    (busy && !lastDone) |=> $stable(addrReg))
    else $error("Address changed during a transfer");
  a_high_byte_out: assert property (@(posedge clk) disable iff (!arst_n)
    (secondStart && isWrite) |=> port_data_lines_out == dataWord[15:8])
    else $error("High byte not placed on the bus");
  a_read_low_first: assert property (@(posedge clk) disable iff (!arst_n)
    (engDone && !isWrite && !byteSel) |=> readWord[7:0] == $past(eng.rdByte))
    else $error("First read byte not stored low");
  a_write_drives_bus: assert property (@(posedge clk) disable iff (!arst_n)
    (engActive && isWrite) |-> port_data_lines_oe && !port_read_strobe)
    else $error("Write cycle without bus drive");
  a_idle_no_select: assert property (@(posedge clk) disable iff (!arst_n)
    !busy |-> !port_chip_select)
    else $error("Chip select while not busy");

endmodule

// ===== verilog/pp_pkg.sv
package pp_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFF_MODE = 12'h000;
  localparam logic [11:0] OFF_ADDR = 12'h004;
  localparam logic [11:0] OFF_DATA = 12'h008;
  localparam logic [11:0] OFF_STAT = 12'h00c;
  localparam logic [11:0] OFF_MASK = 12'h010;

  // ==========================================================================
  // Mode register fields
  localparam int BUSY_BIT = 15;
  localparam int IRQ_HI = 14;
  localparam int IRQ_LO = 13;
  localparam int STEP_HI = 12;
  localparam int STEP_LO = 11;
  localparam int WIDE_BIT = 10;
  localparam int MODE_HI = 9;
  localparam int MODE_LO = 8;
  localparam int SETUP_HI = 7;
  localparam int SETUP_LO = 6;
  localparam int STROBE_HI = 5;
  localparam int STROBE_LO = 2;
  localparam int HOLD_HI = 1;
  localparam int HOLD_LO = 0;
  localparam logic [14:0] MODE_RESET = 15'h0000;
  localparam logic [10:0] ADDR_RESET = 11'h000;

  // ==========================================================================
  // Field codes
  localparam logic [1:0] PORT_SLAVE_LEGACY = 2'h0;
  localparam logic [1:0] PORT_SLAVE_ENH = 2'h1;
  localparam logic [1:0] PORT_MASTER2 = 2'h2;
  localparam logic [1:0] PORT_MASTER1 = 2'h3;
  localparam logic [1:0] IRQ_NONE = 2'h0;
  localparam logic [1:0] IRQ_EACH = 2'h1;
  localparam logic [1:0] IRQ_OFF = 2'h2;
  localparam logic [1:0] IRQ_BUFFER = 2'h3;
  localparam logic [1:0] STEP_HOLD = 2'h0;
  localparam logic [1:0] STEP_UP = 2'h1;
  localparam logic [1:0] STEP_DOWN = 2'h2;
  localparam logic [1:0] STEP_BUFFER = 2'h3;
  localparam logic [1:0] BUF_LAST = 2'h3;
  localparam logic [3:0] STROBE_MIN = 4'h0;
  localparam logic [4:0] LEN_ONE = 5'h01;

  // ==========================================================================
  // Bus cycle phases
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_SETUP = 2'b01,
    PH_STROBE = 2'b11,
    PH_HOLD = 2'b10
  } phase_t;

endpackage

// ===== verilog/strobe_engine.sv
`timescale 1ns/1ps
module strobe_engine (
  input wire logic clk,
  input wire logic arst_n,
  strobe_if.engine bus
);

  pp_pkg::phase_t state;
  pp_pkg::phase_t next_state;
  logic [4:0] cnt;
  logic [4:0] nextLen;
  logic [4:0] phaseCnt;
  logic lastCycle;

  // ==========================================================================
  // Phase sequencing
  assign lastCycle = (cnt == pp_pkg::LEN_ONE);
  assign bus.phase = state;
  assign bus.done = (state == pp_pkg::PH_HOLD) && lastCycle;

  always_comb begin
    case (state)
      pp_pkg::PH_IDLE: next_state = bus.start ? pp_pkg::PH_SETUP : pp_pkg::PH_IDLE;
      pp_pkg::PH_SETUP: next_state = lastCycle ? pp_pkg::PH_STROBE : pp_pkg::PH_SETUP;
      pp_pkg::PH_STROBE: next_state = lastCycle ? pp_pkg::PH_HOLD : pp_pkg::PH_STROBE;
      pp_pkg::PH_HOLD: next_state = lastCycle ? pp_pkg::PH_IDLE : pp_pkg::PH_HOLD;
      default: next_state = pp_pkg::PH_IDLE;
    endcase
  end

  assign nextLen = (next_state == pp_pkg::PH_SETUP) ? bus.setupLen :
                   (next_state == pp_pkg::PH_STROBE) ? bus.strobeLen :
                   (next_state == pp_pkg::PH_HOLD) ? bus.holdLen : pp_pkg::LEN_ONE;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= pp_pkg::PH_IDLE;
      cnt <= pp_pkg::LEN_ONE;
    end else begin
      state <= next_state;
      if (state != next_state) begin
        cnt <= nextLen;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
      end
    end
  end

  // Read data is taken on the last strobe cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus.rdByte <= 8'h00;
    end else if ((state == pp_pkg::PH_STROBE) && lastCycle && !bus.isWrite) begin
      bus.rdByte <= bus.rdIn;
    end
  end

  // ==========================================================================
  // Checks
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      phaseCnt <= pp_pkg::LEN_ONE;
    end else if (state != next_state) begin
      phaseCnt <= pp_pkg::LEN_ONE;
    end else begin
      phaseCnt <= phaseCnt + 5'h01;
    end
  end

  a_setup_length: assert property (@(posedge clk) disable iff (!arst_n)
    (state == pp_pkg::PH_SETUP && next_state != pp_pkg::PH_SETUP) |-> phaseCnt == bus.setupLen)
    else $error("Setup phase length wrong");
  a_strobe_length: assert property (@(posedge clk) disable iff (!arst_n)
    (state == pp_pkg::PH_STROBE && next_state != pp_pkg::PH_STROBE)
      |-> phaseCnt == bus.strobeLen)
    else $error("Strobe phase length wrong");
  a_hold_length: assert property (@(posedge clk) disable iff (!arst_n)
    (state == pp_pkg::PH_HOLD && next_state != pp_pkg::PH_HOLD) |-> phaseCnt == bus.holdLen)
    else $error("Hold phase length wrong");

endmodule

// ===== verilog/strobe_if.sv
`timescale 1ns/1ps
interface strobe_if;
  logic start;
  logic isWrite;
  logic [4:0] setupLen;
  logic [4:0] strobeLen;
  logic [4:0] holdLen;
  logic [7:0] rdIn;
  pp_pkg::phase_t phase;
  logic done;
  logic [7:0] rdByte;

  modport engine (
    input start, isWrite, setupLen, strobeLen, holdLen, rdIn,
    output phase, done, rdByte
  );
  modport ctrl (
    output start, isWrite, setupLen, strobeLen, holdLen, rdIn,
    input phase, done, rdByte
  );
endinterface
